// ### rtl/chan_status_pkg.sv
// chan_status_pkg: register offsets, reset values, frame constants and mode codes
// for the channel status and error counter bank behind the management port.
`default_nettype none
package chan_status_pkg;
    // management frame constants
    localparam logic [4:0]  DEVICE_ADDRESS  = 5'h1e;
    localparam logic [1:0]  FRAME_START     = 2'h0;
    localparam logic [1:0]  OP_ADDRESS      = 2'h0;
    localparam logic [1:0]  OP_READ_INC     = 2'h2;
    localparam logic [5:0]  PREAMBLE_BITS   = 6'h20;
    localparam logic [4:0]  HEAD_BITS       = 5'h0e;
    localparam logic [4:0]  DATA_LAST       = 5'h0f;
    // register offsets
    localparam logic [15:0] CHANNEL_FLAGS_OFFSET   = 16'h000f;
    localparam logic [15:0] HIGH_SPEED_ERR_OFFSET  = 16'h0010;
    localparam logic [15:0] LANE0_ERR_OFFSET       = 16'h0011;
    localparam logic [15:0] LANE1_ERR_OFFSET       = 16'h0012;
    // values after reset and the counter ceiling
    localparam logic [15:0] CHANNEL_FLAGS_RESET    = 16'h0000;
    localparam logic [15:0] ERR_COUNT_RESET        = 16'hfffd;
    localparam logic [15:0] ERR_COUNT_RESET_KR     = 16'h0000;
    localparam logic [15:0] ERR_COUNT_MAX          = 16'hffff;
    // channel flag bit positions
    localparam int BIT_GAIN_LOCK   = 11;
    localparam int BIT_FAST_SYNC   = 10;
    localparam int BIT_BAD_CODE    = 8;
    localparam int BIT_TX_UNDER    = 7;
    localparam int BIT_TX_OVER     = 6;
    localparam int BIT_RX_UNDER    = 5;
    localparam int BIT_RX_OVER     = 4;
    localparam int BIT_SYS_LINK    = 3;
    localparam int BIT_ALIGN_LINK  = 2;
    localparam int BIT_SLOW_PLL    = 1;
    localparam int BIT_FAST_PLL    = 0;
    // operating modes
    localparam logic [1:0]  MODE_10G  = 2'h0;
    localparam logic [1:0]  MODE_KR   = 2'h1;
    localparam logic [1:0]  MODE_KX   = 2'h2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HEAD,
        ST_TURN,
        ST_DATA
    } mdio_state_t;
endpackage : chan_status_pkg
`default_nettype wire

// ### rtl/channel_status_error_counters.sv
// channel_status_error_counters: read-only channel flags and clear-on-read
// error counters, reached through a clause 45 style management slave.
// assumes mdc and mdio_in are already synchronous to sys_clk and that mdc runs
// well below sys_clk; the board resolves mdio from mdio_out and mdio_oe.
//
// Behaviour
// - flag bit 11 follows gain control loop lock.
// - flag bit 10 shows fast side channel synchronisation.
// - flag bit 8 shows invalid code word or disparity error.
// - flag bit 7 shows transmit FIFO underflow, never in KX mode.
// - flag bit 6 shows transmit FIFO overflow in KR and 10G modes.
// - flag bit 5 shows receive FIFO underflow, never in KX mode.
// - flag bit 4 shows receive overflow, or any receive FIFO error in KX.
// - flag bit 3 shows system side link, 10G mode only.
// - flag bit 2 shows alignment or training slave synchronised.
// - flag bit 1 shows slow SerDes PLL locked.
// - flag bit 0 shows fast SerDes PLL locked.
// - fast side counter counts invalid code words in functional operation.
// - reading fast counter clears it; in KR also clears code-group errors.
// - fast counter counts selected test pattern errors in pattern mode.
// - with PRBS pin high, fast counter counts PRBS errors.
// - fast counter resets to fffd, or zero in KR mode.
// - lane counters count decoder errors, or alignment slave errors in 10G.
// - lane counters count selected low-speed test pattern errors.
// - reading a lane counter returns it and clears it.
// - counters sit at 0x10 to 0x12 under device address 0x1e.
// - flags sit at 0x0f and reset to zero.
`default_nettype none
module channel_status_error_counters
    import chan_status_pkg::*;
#(
    parameter logic [4:0] port_address = 5'h00
) (
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        ce,
    // management pins
    input  wire logic        mdc,
    input  wire logic        mdio_in,
    output logic             mdio_out,
    output logic             mdio_oe,
    // operating mode and test selection
    input  wire logic [1:0]  op_mode,
    input  wire logic        fast_test_mode,
    input  wire logic [2:0]  fast_pattern_select,
    input  wire logic        slow_test_mode,
    input  wire logic [1:0]  slow_pattern_select,
    input  wire logic        prbs_check_pin,
    // status levels from the datapath
    input  wire logic        gain_loop_locked,
    input  wire logic        fast_side_synced,
    input  wire logic        bad_codeword_seen,
    input  wire logic        tx_fifo_underflow,
    input  wire logic        tx_fifo_overflow,
    input  wire logic        rx_fifo_underflow,
    input  wire logic        rx_fifo_overflow,
    input  wire logic        rx_fifo_error,
    input  wire logic        system_side_link_up,
    input  wire logic        align_slave_link_up,
    input  wire logic        slow_serdes_pll_locked,
    input  wire logic        fast_serdes_pll_locked,
    // error events, one per cycle at most
    input  wire logic        fast_decode_error,
    input  wire logic [7:0]  fast_pattern_error,
    input  wire logic        prbs_error,
    input  wire logic [1:0]  lane_decode_error,
    input  wire logic [1:0]  lane_align_error,
    input  wire logic [3:0]  lane0_pattern_error,
    input  wire logic [3:0]  lane1_pattern_error,
    // side effect of a fast counter read
    output logic             kr_codegroup_clear
);

    typedef struct packed {
        mdio_state_t  st;
        logic [5:0]   pre;
        logic [4:0]   bits;
        logic [15:0]  shreg;
        logic [15:0]  addr;
        logic [1:0]   op;
        logic         hit;
        logic [15:0]  tx;
        logic         mdio_out;
        logic         mdio_oe;
        logic         mdc_prev;
        logic [15:0]  flags;
        logic [15:0]  fast_side_error_tally;
        logic [15:0]  lane0_error_tally;
        logic [15:0]  lane1_error_tally;
        logic         kr_clear;
    } state_t;

    state_t       cur;
    state_t       next_cur;
    logic [15:0]  flags_word;
    logic         fast_inc;
    logic         lane0_inc;
    logic         lane1_inc;
    logic         rd_fast;
    logic         rd_lane0;
    logic         rd_lane1;
    logic         mdc_rise;
    logic [13:0]  head;

    // saturating count with clear; an error in the clearing cycle counts as one
    function automatic logic [15:0] bump(input logic [15:0] count, input logic clr, input logic inc);
        logic [15:0] base;
        base = clr ? 16'h0000 : count;
        if (inc && base != ERR_COUNT_MAX) begin
            base = base + 16'h0001;
        end
        return base;
    endfunction : bump

    // flag word from live levels, gated by the mode each bit applies in
    always_comb begin
        flags_word                 = CHANNEL_FLAGS_RESET;
        flags_word[BIT_GAIN_LOCK]  = gain_loop_locked;
        flags_word[BIT_FAST_SYNC]  = fast_side_synced;
        flags_word[BIT_BAD_CODE]   = bad_codeword_seen;
        flags_word[BIT_TX_UNDER]   = tx_fifo_underflow && op_mode != MODE_KX;
        flags_word[BIT_TX_OVER]    = tx_fifo_overflow && op_mode != MODE_KX;
        flags_word[BIT_RX_UNDER]   = rx_fifo_underflow && op_mode != MODE_KX;
        // rx overflow or KX fifo error
        flags_word[BIT_RX_OVER]    = (op_mode == MODE_KX) ? rx_fifo_error : rx_fifo_overflow;
        flags_word[BIT_SYS_LINK]   = system_side_link_up && op_mode == MODE_10G;
        flags_word[BIT_ALIGN_LINK] = align_slave_link_up;
        flags_word[BIT_SLOW_PLL]   = slow_serdes_pll_locked;
        flags_word[BIT_FAST_PLL]   = fast_serdes_pll_locked;
    end

    // error sources; the PRBS pin overrides pattern mode, which overrides functional
    always_comb begin
        if (prbs_check_pin) begin
            fast_inc = prbs_error;
        end else if (fast_test_mode) begin
            fast_inc = fast_pattern_error[fast_pattern_select];
        end else begin
            fast_inc = fast_decode_error;
        end
        if (slow_test_mode) begin
            lane0_inc = lane0_pattern_error[slow_pattern_select];
            lane1_inc = lane1_pattern_error[slow_pattern_select];
        end else if (op_mode == MODE_10G) begin
            lane0_inc = lane_align_error[0];
            lane1_inc = lane_align_error[1];
        end else begin
            lane0_inc = lane_decode_error[0];
            lane1_inc = lane_decode_error[1];
        end
    end

    assign mdc_rise = ce && mdc && !cur.mdc_prev;
    assign head     = {cur.shreg[12:0], mdio_in};

    // next state: management frame walker, flag snapshot and counters
    always_comb begin
        next_cur          = cur;
        rd_fast           = 1'b0;
        rd_lane0          = 1'b0;
        rd_lane1          = 1'b0;
        if (ce) begin
            next_cur.mdc_prev = mdc;
            next_cur.flags    = flags_word;
        end
        if (mdc_rise) begin
            case (cur.st)
                ST_IDLE: begin
                    if (mdio_in) begin
                        if (cur.pre != PREAMBLE_BITS) begin
                            next_cur.pre = cur.pre + 6'h01;
                        end
                    end else if (cur.pre == PREAMBLE_BITS) begin
                        next_cur.st    = ST_HEAD;
                        next_cur.bits  = 5'h01;
                        next_cur.shreg = 16'h0000;
                    end else begin
                        next_cur.pre = 6'h00;
                    end
                end
                ST_HEAD: begin
                    next_cur.shreg = {cur.shreg[14:0], mdio_in};
                    next_cur.bits  = cur.bits + 5'h01;
                    if (cur.bits == HEAD_BITS - 5'h01) begin
                        next_cur.op   = head[11:10];
                        // answer only at our device address
                        next_cur.hit  = head[13:12] == FRAME_START && head[9:5] == port_address
                                        && head[4:0] == DEVICE_ADDRESS;
                        next_cur.st   = ST_TURN;
                        next_cur.bits = 5'h00;
                    end
                end
                ST_TURN: begin
                    if (cur.bits == 5'h00) begin
                        next_cur.bits = 5'h01;
                        if (cur.hit && cur.op[1]) begin
                            next_cur.mdio_oe  = 1'b1;
                            next_cur.mdio_out = 1'b0;
                            case (cur.addr)
                                CHANNEL_FLAGS_OFFSET: next_cur.tx = cur.flags;
                                HIGH_SPEED_ERR_OFFSET: begin
                                    next_cur.tx = cur.fast_side_error_tally;
                                    rd_fast     = 1'b1;
                                end
                                LANE0_ERR_OFFSET: begin
                                    next_cur.tx = cur.lane0_error_tally;
                                    rd_lane0    = 1'b1;
                                end
                                LANE1_ERR_OFFSET: begin
                                    next_cur.tx = cur.lane1_error_tally;
                                    rd_lane1    = 1'b1;
                                end
                                default: next_cur.tx = 16'h0000;
                            endcase
                        end
                    end else begin
                        next_cur.bits     = 5'h00;
                        next_cur.st       = ST_DATA;
                        next_cur.mdio_out = cur.mdio_oe & cur.tx[15];
                        next_cur.tx       = {cur.tx[14:0], 1'b0};
                    end
                end
                ST_DATA: begin
                    next_cur.shreg    = {cur.shreg[14:0], mdio_in};
                    next_cur.bits     = cur.bits + 5'h01;
                    next_cur.mdio_out = cur.mdio_oe & cur.tx[15];
                    next_cur.tx       = {cur.tx[14:0], 1'b0};
                    if (cur.bits == DATA_LAST) begin
                        // writes to the read-only words are ignored
                        next_cur.st       = ST_IDLE;
                        next_cur.pre      = 6'h00;
                        next_cur.mdio_oe  = 1'b0;
                        next_cur.mdio_out = 1'b0;
                        if (cur.hit && cur.op == OP_ADDRESS) begin
                            next_cur.addr = {cur.shreg[14:0], mdio_in};
                        end else if (cur.hit && cur.op == OP_READ_INC) begin
                            next_cur.addr = cur.addr + 16'h0001;
                        end
                    end
                end
                default: begin
                    next_cur.st = ST_IDLE;
                end
            endcase
        end
        if (ce) begin
            next_cur.fast_side_error_tally = bump(cur.fast_side_error_tally, rd_fast, fast_inc);
            next_cur.lane0_error_tally     = bump(cur.lane0_error_tally, rd_lane0, lane0_inc);
            next_cur.lane1_error_tally     = bump(cur.lane1_error_tally, rd_lane1, lane1_inc);
            next_cur.kr_clear              = rd_fast && op_mode == MODE_KR;
        end
    end

    // state register; reset values depend on the mode strapped at that time
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur       <= '0;
            cur.st    <= ST_IDLE;
            cur.flags <= CHANNEL_FLAGS_RESET;
            cur.fast_side_error_tally <= (op_mode == MODE_KR) ? ERR_COUNT_RESET_KR : ERR_COUNT_RESET;
            cur.lane0_error_tally     <= ERR_COUNT_RESET;
            cur.lane1_error_tally     <= ERR_COUNT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign mdio_out           = cur.mdio_out;
    assign mdio_oe            = cur.mdio_oe;
    assign kr_codegroup_clear = cur.kr_clear;

    // checks
    sequence s_fast_read;
        rd_fast;
    endsequence

    sequence s_turn_drive;
        cur.st == ST_TURN && cur.bits == 5'h00 && mdc_rise && cur.hit && cur.op[1];
    endsequence

    chk_flag_gain: assert property (@(posedge sys_clk) disable iff (rst)
        ce |=> cur.flags[BIT_GAIN_LOCK] == $past(gain_loop_locked))
        else $error("gain lock flag wrong");

    chk_tx_under_kx: assert property (@(posedge sys_clk) disable iff (rst)
        ce && op_mode == MODE_KX |=> !cur.flags[BIT_TX_UNDER])
        else $error("tx underflow flag set in KX");

    chk_sys_link_mode: assert property (@(posedge sys_clk) disable iff (rst)
        ce && op_mode != MODE_10G |=> !cur.flags[BIT_SYS_LINK])
        else $error("system link flag outside 10G");

    chk_fast_read_clear: assert property (@(posedge sys_clk) disable iff (rst)
        s_fast_read |=> cur.fast_side_error_tally == {15'h0000, $past(fast_inc)})
        else $error("fast counter not cleared by read");

    chk_kr_clear_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        s_fast_read and op_mode == MODE_KR |=> kr_codegroup_clear ##1 !kr_codegroup_clear)
        else $error("code-group clear pulse wrong");

    chk_fast_reset_val: assert property (@(posedge sys_clk) disable iff (rst)
        $past(rst) |-> cur.fast_side_error_tally ==
            (($past(op_mode) == MODE_KR) ? ERR_COUNT_RESET_KR : ERR_COUNT_RESET))
        else $error("fast counter reset value wrong");

    chk_lane0_count: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !rd_lane0 && lane0_inc && cur.lane0_error_tally != ERR_COUNT_MAX
        |=> cur.lane0_error_tally == $past(cur.lane0_error_tally) + 16'h0001)
        else $error("lane 0 counter missed an error");

    chk_lane1_read: assert property (@(posedge sys_clk) disable iff (rst)
        rd_lane1 |=> cur.tx == $past(cur.lane1_error_tally)
                     && cur.lane1_error_tally == {15'h0000, $past(lane1_inc)})
        else $error("lane 1 read did not clear");

    chk_count_saturate: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !rd_fast && cur.fast_side_error_tally == ERR_COUNT_MAX |=> cur.fast_side_error_tally == ERR_COUNT_MAX)
        else $error("fast counter wrapped");

    chk_turn_drive: assert property (@(posedge sys_clk) disable iff (rst)
        s_turn_drive |=> mdio_oe && !mdio_out)
        else $error("turnaround zero not driven");

endmodule : channel_status_error_counters
`default_nettype wire

// ### verif/mdio_station.sv
// mdio_station: management station model that frames address, write and read cycles.
// assumes the device samples mdio on mdc rises that it sees through sys_clk.
`default_nettype none
module mdio_station
    import chan_status_pkg::*;
(
    // clock
    input  wire logic sys_clk,
    // management pins
    output logic      mdc,
    output logic      mdio_in,
    input  wire logic mdio_out,
    input  wire logic mdio_oe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic sta_oe;
    logic sta_bit;

    // wire level: device first, then station, else the pull-up
    assign mdio_in = mdio_oe ? mdio_out : (sta_oe ? sta_bit : 1'b1);

    // mdc stands low outside frames
    initial begin
        mdc = 1'b0;
        sta_oe = 1'b0;
        sta_bit = 1'b1;
    end

    // one bit time, three sys_clk low and four high so the device sees every edge
    task automatic bit_slot(input logic drv, input logic b, output logic seen);
        @(posedge sys_clk);
        #1;
        mdc = 1'b0;
        sta_oe = drv;
        sta_bit = b;
        repeat (3) @(posedge sys_clk);
        #1;
        seen = mdio_in;
        mdc = 1'b1;
        repeat (3) @(posedge sys_clk);
    endtask : bit_slot

    task automatic frame(input int pre, input logic [1:0] op, input logic [4:0] prt,
                         input logic [4:0] dev, input logic [15:0] wd, output logic [15:0] rd);
        logic [13:0] head;
        logic        seen;
        logic        rel;
        head = {FRAME_START, op, prt, dev};
        rel = op[1];
        repeat (pre) bit_slot(1'b1, 1'b1, seen);
        for (int i = 13; i >= 0; i--) bit_slot(1'b1, head[i], seen);
        bit_slot(!rel, 1'b1, seen);
        bit_slot(!rel, 1'b0, seen);
        for (int i = 15; i >= 0; i--) begin
            bit_slot(!rel, wd[i], seen);
            rd[i] = seen;
        end
        @(posedge sys_clk);
        #1;
        mdc = 1'b0;
        sta_oe = 1'b0;
    endtask : frame
endmodule : mdio_station
`default_nettype wire

// ### verif/tb_channel_status_error_counters.sv
// tb_channel_status_error_counters: self-checking bench for the flag word and counters.
// assumes the station model is the only master on the management pins.
`default_nettype none
module tb_channel_status_error_counters
    import chan_status_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [4:0] PRT = 5'h03;
    logic        sys_clk, rst, ce, mdc, mdio_in, mdio_out, mdio_oe, kr_codegroup_clear;
    logic [1:0]  op_mode, slow_pattern_select, lane_decode_error, lane_align_error;
    logic        fast_test_mode, slow_test_mode, prbs_check_pin, fast_decode_error, prbs_error;
    logic [2:0]  fast_pattern_select;
    logic [7:0]  fast_pattern_error;
    logic [3:0]  lane0_pattern_error, lane1_pattern_error;
    logic [11:0] flg;
    logic [15:0] got;
    int          bad_count, total_checks, kr_seen;

    channel_status_error_counters #(.port_address(PRT)) i_dut (
        .sys_clk, .rst, .ce, .mdc, .mdio_in, .mdio_out, .mdio_oe, .op_mode, .fast_test_mode,
        .fast_pattern_select, .slow_test_mode, .slow_pattern_select, .prbs_check_pin,
        .gain_loop_locked(flg[0]), .fast_side_synced(flg[1]), .bad_codeword_seen(flg[2]),
        .tx_fifo_underflow(flg[3]), .tx_fifo_overflow(flg[4]), .rx_fifo_underflow(flg[5]),
        .rx_fifo_overflow(flg[6]), .rx_fifo_error(flg[7]), .system_side_link_up(flg[8]),
        .align_slave_link_up(flg[9]), .slow_serdes_pll_locked(flg[10]), .fast_serdes_pll_locked(flg[11]),
        .fast_decode_error, .fast_pattern_error, .prbs_error, .lane_decode_error, .lane_align_error,
        .lane0_pattern_error, .lane1_pattern_error, .kr_codegroup_clear);
    mdio_station i_sta (.sys_clk, .mdc, .mdio_in, .mdio_out, .mdio_oe);

    // clock and clear-pulse tally
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) if (kr_codegroup_clear === 1'b1) kr_seen <= kr_seen + 1;

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask : tick

    // errors stay high n cycles, then all drop together
    task automatic hit(input int n);
        tick(n);
        {fast_decode_error, prbs_error, fast_pattern_error} = 10'h000;
        {lane_decode_error, lane_align_error, lane0_pattern_error, lane1_pattern_error} = 12'h000;
    endtask : hit

    task automatic do_reset(input logic [1:0] m);
        op_mode = m;
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
    endtask : do_reset

    task automatic mframe(input logic [1:0] op, input logic [15:0] d);
        i_sta.frame(32, op, PRT, DEVICE_ADDRESS, d, got);
    endtask : mframe

    task automatic read_at(input logic [15:0] a, input string nm, input logic [15:0] e);
        mframe(OP_ADDRESS, a);
        mframe(2'h3, 16'h0000);
        check(nm, e, got);
    endtask : read_at

    function automatic logic [15:0] flag_exp(input logic [1:0] m, input int i);
        logic [15:0] e;
        logic        kx;
        kx = (m == MODE_KX);
        e = 16'h0000;
        case (i)
            0: e[BIT_GAIN_LOCK] = 1'b1;
            1: e[BIT_FAST_SYNC] = 1'b1;
            2: e[BIT_BAD_CODE] = 1'b1;
            3: e[BIT_TX_UNDER] = !kx;
            4: e[BIT_TX_OVER] = !kx;
            5: e[BIT_RX_UNDER] = !kx;
            6: e[BIT_RX_OVER] = !kx;
            7: e[BIT_RX_OVER] = kx;
            8: e[BIT_SYS_LINK] = (m == MODE_10G);
            9: e[BIT_ALIGN_LINK] = 1'b1;
            10: e[BIT_SLOW_PLL] = 1'b1;
            default: e[BIT_FAST_PLL] = 1'b1;
        endcase
        return e;
    endfunction : flag_exp

    // reset values, then read-increment walk that clears each counter
    task automatic t_reset();
        read_at(CHANNEL_FLAGS_OFFSET, "flags after reset", CHANNEL_FLAGS_RESET);
        for (int p = 0; p < 2; p++) begin
            mframe(OP_ADDRESS, HIGH_SPEED_ERR_OFFSET);
            for (int r = 0; r < 3; r++) begin
                mframe(OP_READ_INC, 16'h0000);
                check("counter walk", p == 0 ? ERR_COUNT_RESET : 16'h0000, got);
            end
        end
        mframe(2'h3, 16'h0000);
        check("unmapped", 16'h0000, got);
        check("clear pulse in 10g", 16'h0000, 16'(kr_seen));
    endtask : t_reset

    // one flag input at a time in every mode
    task automatic t_flags();
        mframe(OP_ADDRESS, CHANNEL_FLAGS_OFFSET);
        for (int m = 0; m < 3; m++) begin
            for (int i = 0; i < 12; i++) begin
                op_mode = 2'(m);
                flg = 12'h001 << i;
                tick(2);
                mframe(2'h3, 16'h0000);
                check("flag word", flag_exp(2'(m), i), got);
            end
        end
        flg = 12'h000;
        op_mode = MODE_10G;
    endtask : t_flags

    // every error source with the others shouting alongside
    task automatic t_count();
        {fast_decode_error, prbs_error} = 2'h3;
        hit(5);
        read_at(HIGH_SPEED_ERR_OFFSET, "functional", 16'h0005);
        {prbs_check_pin, fast_test_mode} = 2'h3;
        {prbs_error, fast_decode_error, fast_pattern_error} = 10'h3ff;
        hit(3);
        read_at(HIGH_SPEED_ERR_OFFSET, "prbs", 16'h0003);
        prbs_check_pin = 1'b0;
        for (int s = 0; s < 8; s++) begin
            fast_pattern_select = 3'(s);
            fast_pattern_error = 8'h01 << s;
            fast_decode_error = 1'b1;
            hit(s + 1);
            fast_pattern_error = ~(8'h01 << s);
            hit(2);
            read_at(HIGH_SPEED_ERR_OFFSET, "fast pattern", 16'(s + 1));
        end
        {fast_test_mode, slow_test_mode} = 2'h1;
        for (int s = 0; s < 4; s++) begin
            slow_pattern_select = 2'(s);
            lane0_pattern_error = 4'h1 << s;
            lane1_pattern_error = ~(4'h1 << s);
            lane_decode_error = 2'h3;
            hit(s + 1);
            read_at(LANE0_ERR_OFFSET, "lane0 pattern", 16'(s + 1));
            read_at(LANE1_ERR_OFFSET, "lane1 pattern", 16'h0000);
        end
        slow_test_mode = 1'b0;
        for (int k = 0; k < 2; k++) begin
            op_mode = k == 0 ? MODE_10G : MODE_KR;
            {lane_align_error, lane_decode_error} = 4'h6;
            hit(4);
            read_at(LANE0_ERR_OFFSET, "lane0 source", k == 0 ? 16'h0004 : 16'h0000);
            read_at(LANE1_ERR_OFFSET, "lane1 source", k == 0 ? 16'h0000 : 16'h0004);
        end
        op_mode = MODE_10G;
    endtask : t_count

    // refused frames, an ignored write and a frozen clock enable leave the count alone
    task automatic t_refuse();
        mframe(OP_ADDRESS, HIGH_SPEED_ERR_OFFSET);
        fast_decode_error = 1'b1;
        hit(2);
        i_sta.frame(31, 2'h3, PRT, DEVICE_ADDRESS, 16'h0000, got);
        check("short preamble", 16'hffff, got);
        i_sta.frame(32, 2'h3, PRT ^ 5'h01, DEVICE_ADDRESS, 16'h0000, got);
        check("other port", 16'hffff, got);
        i_sta.frame(32, 2'h3, PRT, DEVICE_ADDRESS ^ 5'h01, 16'h0000, got);
        check("other device", 16'hffff, got);
        mframe(2'h1, 16'h1234);
        ce = 1'b0;
        fast_decode_error = 1'b1;
        hit(3);
        ce = 1'b1;
        mframe(2'h3, 16'h0000);
        check("count kept", 16'h0002, got);
    endtask : t_refuse

    // fast side reset value per mode, side-effect pulse, saturation
    task automatic t_kr();
        do_reset(MODE_KR);
        read_at(HIGH_SPEED_ERR_OFFSET, "kr reset value", ERR_COUNT_RESET_KR);
        check("clear pulse in kr", 16'h0001, 16'(kr_seen));
        do_reset(MODE_10G);
        fast_decode_error = 1'b1;
        hit(4);
        read_at(HIGH_SPEED_ERR_OFFSET, "saturated", ERR_COUNT_MAX);
    endtask : t_kr

    // main sequence
    initial begin
        {bad_count, total_checks} = '0;
        {rst, ce, fast_test_mode, slow_test_mode, prbs_check_pin} = 5'h18;
        {fast_pattern_select, slow_pattern_select, flg} = 17'h00000;
        hit(0);
        do_reset(MODE_10G);
        t_reset();
        t_flags();
        t_count();
        t_refuse();
        t_kr();
        final_report();
    end

    // watchdog bounds the whole run
    initial begin
        repeat (99000) @(posedge sys_clk);
        bad_count++;
        $display("wrong value run length expected done seen timeout");
        final_report();
    end
endmodule : tb_channel_status_error_counters
`default_nettype wire
